/* common/dasr_pkg.sv */
// Shared constants and types for the dual converter readout and power mode controller.
package dasr_pkg;

  // Width of each channel result word shifted out on a data lane.
  localparam int unsigned RESULT_W = 16;

  // System clock rate used to turn times into cycle counts.
  localparam int unsigned CLK_SYS_MHZ = 100;

  // Quiet time after a supply fault before conversions are trustworthy.
  localparam int unsigned POR_WAIT_MS     = 10;
  localparam int unsigned POR_WAIT_CYCLES = POR_WAIT_MS * 1000 * CLK_SYS_MHZ;
  localparam int unsigned POR_CNT_W       = 24;

  // Conversion length of the analog core, rounded up to whole cycles.
  localparam int unsigned CONV_TIME_NS     = 150;
  localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int unsigned CONV_CNT_W       = 8;

  // Idle convert pulse counts that move the power state.
  localparam int unsigned IDLE_CNT_W       = 3;
  localparam logic [2:0]  NAP_PULSES       = 3'h2;
  localparam logic [2:0]  SLEEP_PULSES     = 3'h4;
  localparam logic [2:0]  WAKE_PULSES      = 3'h5;

  // Reset values of the control state.
  localparam logic [2:0]  IDLE_CNT_RESET   = 3'h0;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_RESET = 8'h00;
  localparam logic [RESULT_W-1:0]   WORD_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    PWR_OPER,
    PWR_NAP,
    PWR_SLEEP
  } dasr_pwr_t;

endpackage : dasr_pkg

/* rtl/dasr_top.sv */
// Convert strobe handling, power modes and dual-lane serial readout of the converter.
`timescale 1ns/1ns
// What the document requires
// [R01] Convert rising edge starts sampling.
// [R02] Convert falling edge holds and starts conversion.
// [R03] Host keeps convert pulse at least 35 ns.
// [R04] Shift result MSB first on sck falling.
// [R05] Host runs sck at 105 MHz.
// [R06] Echoed clock follows sck, matched to data.
// [R07] Board may disable echoed clock pin; the echo here has no disable and always runs.
// [R08] Two idle convert pulses enter nap.
// [R09] Nap ends on sck rise or more pulses.
// [R10] Two more idle pulses move nap to sleep.
// [R11] Single-ended: sck rise wakes from sleep.
// [R12] Host waits 10 ms after sleep wake.
// [R13] Fifth idle convert pulse wakes from sleep.
// [R14] Sck activity clears idle pulse count.
// [R15] Idle convert pulses cycle states endlessly.
// [R16] Reset on supply fault, reinitialise after.
// [R17] Host waits 10 ms after reset.
// [R18] First result after idle flagged invalid.
// [R19] Static pin selects single-ended or differential.
// [R20] Single-ended: negative pins held low.
// [R21] Differential: outputs driven as pairs.
// [R22] Both channels shift out together.
module dasr_top
  import dasr_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_WAIT_CYCLES
) (
  // System clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  // Host link pins
  input  wire logic                convert_strobe_i,
  input  wire logic                link_sck_i,
  input  wire logic                io_diff_select_i,
  output logic                     channel_one_serial_out_p_o,
  output logic                     channel_one_serial_out_n_o,
  output logic                     channel_two_serial_out_p_o,
  output logic                     channel_two_serial_out_n_o,
  output logic                     echoed_capture_clock_p_o,
  output logic                     echoed_capture_clock_n_o,
  // Analog core
  input  wire logic                supply_ok_i,
  input  wire logic [RESULT_W-1:0] ch1_code_i,
  input  wire logic [RESULT_W-1:0] ch2_code_i,
  output logic                     sample_hold_o,
  output logic                     conv_start_o,
  // Status
  output logic                     nap_o,
  output logic                     sleep_o,
  output logic                     ready_o,
  output logic                     result_invalid_o
);

  // Pin synchronisers in the system domain.
  logic cnv_meta_reg, cnv_sync_reg, cnv_prev_reg;
  logic sup_meta_reg, sup_sync_reg;
  logic mode_meta_reg, mode_sync_reg;
  logic sckr_meta_reg, sckr_sync_reg, sckr_prev_reg;
  logic sck_rise_tgl_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnv_meta_reg  <= 1'b0;
      cnv_sync_reg  <= 1'b0;
      cnv_prev_reg  <= 1'b0;
      sup_meta_reg  <= 1'b0;
      sup_sync_reg  <= 1'b0;
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      sckr_meta_reg <= 1'b0;
      sckr_sync_reg <= 1'b0;
      sckr_prev_reg <= 1'b0;
    end else begin
      cnv_meta_reg  <= convert_strobe_i;
      cnv_sync_reg  <= cnv_meta_reg;
      cnv_prev_reg  <= cnv_sync_reg;
      sup_meta_reg  <= supply_ok_i;
      sup_sync_reg  <= sup_meta_reg;
      mode_meta_reg <= io_diff_select_i;
      mode_sync_reg <= mode_meta_reg;
      sckr_meta_reg <= sck_rise_tgl_reg;
      sckr_sync_reg <= sckr_meta_reg;
      sckr_prev_reg <= sckr_sync_reg;
    end
  end

  logic cnv_rise, cnv_fall, sck_rise_evt;
  assign cnv_rise     = cnv_sync_reg & ~cnv_prev_reg;
  assign cnv_fall     = ~cnv_sync_reg & cnv_prev_reg;
  assign sck_rise_evt = sckr_sync_reg ^ sckr_prev_reg;

  // Power-on reset timer; a supply dip restarts the whole wait.
  logic [POR_CNT_W-1:0] por_cnt_reg;
  logic                 ready_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt_reg <= '0;
      ready_reg   <= 1'b0;
    end else if (!sup_sync_reg) begin
      por_cnt_reg <= '0; // [R16]
      ready_reg   <= 1'b0;
    end else if (!ready_reg) begin
      if (por_cnt_reg == POR_CNT_W'(POR_CYCLES - 1)) begin
        ready_reg <= 1'b1;
      end
      por_cnt_reg <= por_cnt_reg + 1'b1;
    end
  end

  // Power state: idle convert pulses walk nap, sleep and back.
  dasr_pwr_t             pwr_reg;
  logic [IDLE_CNT_W-1:0] idle_cnt_reg;
  logic [IDLE_CNT_W-1:0] idle_cnt_next;
  assign idle_cnt_next = idle_cnt_reg + 1'b1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_reg      <= PWR_OPER;
      idle_cnt_reg <= IDLE_CNT_RESET;
    end else if (!sup_sync_reg) begin
      pwr_reg      <= PWR_OPER; // [R16]
      idle_cnt_reg <= IDLE_CNT_RESET;
    end else if (sck_rise_evt) begin
      idle_cnt_reg <= IDLE_CNT_RESET; // [R14]
      case (pwr_reg)
        PWR_NAP:   pwr_reg <= PWR_OPER; // [R09]
        PWR_SLEEP: begin
          if (!mode_sync_reg) begin
            pwr_reg <= PWR_OPER; // [R11]
          end
        end
        default:   pwr_reg <= pwr_reg;
      endcase
    end else if (cnv_rise) begin
      if (idle_cnt_next == WAKE_PULSES) begin
        pwr_reg      <= PWR_OPER; // [R13] [R15]
        idle_cnt_reg <= IDLE_CNT_RESET;
      end else begin
        idle_cnt_reg <= idle_cnt_next;
        if (idle_cnt_next == NAP_PULSES) begin
          pwr_reg <= PWR_NAP; // [R08]
        end else if (idle_cnt_next == SLEEP_PULSES) begin
          pwr_reg <= PWR_SLEEP; // [R10]
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nap_o   <= 1'b0;
      sleep_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      nap_o   <= (pwr_reg == PWR_NAP);
      sleep_o <= (pwr_reg == PWR_SLEEP);
      ready_o <= ready_reg;
    end
  end

  // Sample-and-hold control and conversion timing.
  logic                  conv_busy_reg;
  logic [CONV_CNT_W-1:0] conv_cnt_reg;
  logic                  conv_done;
  assign conv_done = conv_busy_reg && (conv_cnt_reg == CONV_CNT_W'(CONV_CYCLES - 1));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_hold_o <= 1'b0;
      conv_start_o  <= 1'b0;
    end else begin
      if (cnv_rise) begin
        sample_hold_o <= 1'b1; // [R01]
      end else if (cnv_fall) begin
        sample_hold_o <= 1'b0; // [R02]
      end
      conv_start_o <= cnv_fall && sup_sync_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_busy_reg <= 1'b0;
      conv_cnt_reg  <= CONV_CNT_RESET;
    end else if (cnv_fall && sup_sync_reg) begin
      conv_busy_reg <= 1'b1; // [R02]
      conv_cnt_reg  <= CONV_CNT_RESET;
    end else if (conv_done) begin
      conv_busy_reg <= 1'b0;
    end else if (conv_busy_reg) begin
      conv_cnt_reg  <= conv_cnt_reg + 1'b1;
    end
  end

  // Result words are held steady here and handed to the link by a toggle.
  // A conversion that ends before the previous word is shifted out replaces it.
  logic [RESULT_W-1:0] word1_reg, word2_reg;
  logic                word_tgl_reg;
  logic                burst_first_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word1_reg    <= WORD_RESET;
      word2_reg    <= WORD_RESET;
      word_tgl_reg <= 1'b0;
    end else if (conv_done) begin
      word1_reg    <= ch1_code_i;
      word2_reg    <= ch2_code_i;
      word_tgl_reg <= ~word_tgl_reg;
    end
  end

  // The first word after any idle spell carries a stale reference, so it is flagged.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_first_reg  <= 1'b1;
      result_invalid_o <= 1'b1;
    end else begin
      if (pwr_reg != PWR_OPER || !ready_reg) begin
        burst_first_reg <= 1'b1; // [R18]
      end else if (conv_done) begin
        burst_first_reg <= 1'b0;
      end
      if (conv_done) begin
        result_invalid_o <= burst_first_reg || !ready_reg; // [R18]
      end
    end
  end

  // Link domain: rising sck edges are reported back as a toggle.
  always_ff @(posedge link_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_rise_tgl_reg <= 1'b0;
    end else begin
      sck_rise_tgl_reg <= ~sck_rise_tgl_reg; // [R09] [R14]
    end
  end

  // Link domain on falling sck edges: word handover, shifting, pair outputs.
  logic                wt_meta_reg, wt_sync_reg, wt_prev_reg;
  logic                md_meta_reg, md_sync_reg;
  logic                echo_neg_tgl_reg;
  logic [RESULT_W-1:0] shift1_reg, shift2_reg;
  logic                word_load;
  assign word_load = wt_sync_reg ^ wt_prev_reg;

  always_ff @(negedge link_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wt_meta_reg      <= 1'b0;
      wt_sync_reg      <= 1'b0;
      wt_prev_reg      <= 1'b0;
      md_meta_reg      <= 1'b0;
      md_sync_reg      <= 1'b0;
      echo_neg_tgl_reg <= 1'b0;
    end else begin
      wt_meta_reg      <= word_tgl_reg;
      wt_sync_reg      <= wt_meta_reg;
      wt_prev_reg      <= wt_sync_reg;
      md_meta_reg      <= io_diff_select_i; // [R19]
      md_sync_reg      <= md_meta_reg;
      echo_neg_tgl_reg <= ~echo_neg_tgl_reg;
    end
  end

  always_ff @(negedge link_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift1_reg                 <= WORD_RESET;
      shift2_reg                 <= WORD_RESET;
      channel_one_serial_out_p_o <= 1'b0;
      channel_two_serial_out_p_o <= 1'b0;
    end else if (word_load) begin
      shift1_reg                 <= word1_reg;
      shift2_reg                 <= word2_reg;
      channel_one_serial_out_p_o <= word1_reg[RESULT_W-1]; // [R04] [R22]
      channel_two_serial_out_p_o <= word2_reg[RESULT_W-1];
    end else begin
      shift1_reg                 <= {shift1_reg[RESULT_W-2:0], 1'b0};
      shift2_reg                 <= {shift2_reg[RESULT_W-2:0], 1'b0};
      channel_one_serial_out_p_o <= shift1_reg[RESULT_W-2]; // [R04] [R22]
      channel_two_serial_out_p_o <= shift2_reg[RESULT_W-2];
    end
  end

  // Negative lanes are complements in differential mode and low otherwise.
  always_ff @(negedge link_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_one_serial_out_n_o <= 1'b0;
      channel_two_serial_out_n_o <= 1'b0;
    end else if (md_sync_reg) begin
      channel_one_serial_out_n_o <= word_load ? ~word1_reg[RESULT_W-1]
                                              : ~shift1_reg[RESULT_W-2]; // [R21]
      channel_two_serial_out_n_o <= word_load ? ~word2_reg[RESULT_W-1]
                                              : ~shift2_reg[RESULT_W-2];
    end else begin
      channel_one_serial_out_n_o <= 1'b0; // [R20]
      channel_two_serial_out_n_o <= 1'b0;
    end
  end

  // The echo is rebuilt from one flop per sck edge so it tracks sck with flop delay,
  // the same delay the data lanes see; a single flop cannot follow both edges.
  logic echo_clk;
  assign echo_clk                 = sck_rise_tgl_reg ^ echo_neg_tgl_reg; // [R06]
  assign echoed_capture_clock_p_o = echo_clk;
  assign echoed_capture_clock_n_o = md_sync_reg & ~echo_clk; // [R20] [R21]

  // Checks in the system domain, with the two lane checks on falling sck edges.
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_idle_pulse;
    cnv_rise && !sck_rise_evt && sup_sync_reg;
  endsequence

  sequence s_sck_wake;
    sck_rise_evt && sup_sync_reg;
  endsequence

  chk_cnv_rise_samples: assert property (cnv_rise |=> sample_hold_o) // [R01]
    else $error("Sampling did not start on convert rise.");
  chk_cnv_fall_holds: assert property ( // [R02]
    cnv_fall && sup_sync_reg |=> !sample_hold_o && conv_start_o ##1 !conv_start_o)
    else $error("Hold or conversion start missing on convert fall.");
  chk_nap_entry: assert property ( // [R08]
    pwr_reg == PWR_OPER && idle_cnt_reg == 3'h1 ##0 s_idle_pulse |=> pwr_reg == PWR_NAP)
    else $error("Second idle convert pulse did not enter nap.");
  chk_nap_wake: assert property ( // [R09]
    pwr_reg == PWR_NAP ##0 s_sck_wake |=> pwr_reg == PWR_OPER)
    else $error("Sck rise did not end nap.");
  chk_sleep_entry: assert property ( // [R10]
    pwr_reg == PWR_NAP && idle_cnt_reg == 3'h3 ##0 s_idle_pulse |=> pwr_reg == PWR_SLEEP)
    else $error("Two more idle pulses did not enter sleep.");
  chk_se_wake: assert property ( // [R11]
    pwr_reg == PWR_SLEEP && !mode_sync_reg ##0 s_sck_wake |=> pwr_reg == PWR_OPER)
    else $error("Single-ended sck rise did not wake from sleep.");
  chk_fifth_wake: assert property ( // [R13]
    pwr_reg == PWR_SLEEP && idle_cnt_reg == 3'h4 ##0 s_idle_pulse
    |=> pwr_reg == PWR_OPER && idle_cnt_reg == 3'h0)
    else $error("Fifth idle pulse did not wake from sleep.");
  chk_sck_clears: assert property (s_sck_wake |=> idle_cnt_reg == 3'h0) // [R14]
    else $error("Sck activity did not clear idle count.");
  chk_por_hold: assert property (!sup_sync_reg |=> !ready_reg ##1 !ready_o) // [R16]
    else $error("Ready survived a supply fault.");
  chk_invalid_first: assert property ( // [R18]
    conv_done && burst_first_reg |=> result_invalid_o)
    else $error("First result after idle not flagged invalid.");
  chk_shift_msb: assert property (@(negedge link_sck_i) disable iff (!rst_n_i) // [R04]
    word_load |=> channel_one_serial_out_p_o == shift1_reg[RESULT_W-1]
              && channel_two_serial_out_p_o == shift2_reg[RESULT_W-1])
    else $error("Lanes did not start with the word MSB.");
  chk_diff_pairs: assert property (@(negedge link_sck_i) disable iff (!rst_n_i) // [R21]
    md_sync_reg ##1 md_sync_reg |-> channel_one_serial_out_n_o != channel_one_serial_out_p_o
    && channel_two_serial_out_n_o != channel_two_serial_out_p_o)
    else $error("Differential lanes are not complements.");

endmodule : dasr_top

/* test/dasr_host_model.sv */
// Host logic model that drives the convert strobe and serial clock and captures both lanes.
`timescale 1ns/1ns
module dasr_host_model
  import dasr_pkg::*;
(
  // Clock reference
  input  wire logic clk_sys_i,
  // Data and echo pins from the converter
  input  wire logic lane1_p_i,
  input  wire logic lane1_n_i,
  input  wire logic lane2_p_i,
  input  wire logic lane2_n_i,
  input  wire logic echo_p_i,
  input  wire logic echo_n_i,
  // Host drive
  output logic      convert_strobe_o,
  output logic      link_sck_o
);
  initial begin
    convert_strobe_o = 1'b0;
    link_sck_o       = 1'b0;
  end

  // Six cycles high is well above the minimum pulse width.
  task automatic cnv_pulse();
    @(negedge clk_sys_i);
    convert_strobe_o = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    convert_strobe_o = 1'b0;
    repeat (25) @(negedge clk_sys_i);
  endtask : cnv_pulse

  // The echo negative pin is only watched, never tied high, so the echo stays on.
  function automatic int lane_fault(input logic diff);
    logic ok;
    ok = (echo_p_i === link_sck_o) && (diff ?
         (echo_n_i === ~echo_p_i && lane1_n_i === ~lane1_p_i && lane2_n_i === ~lane2_p_i) :
         ({echo_n_i, lane1_n_i, lane2_n_i} === 3'h0));
    return ok ? 0 : 1;
  endfunction : lane_fault

  // The serial clock idles low between frames and runs at 80 ns, slower than the full rate.
  task automatic sck_frame(input int n, input logic diff, output logic [RESULT_W-1:0] w1,
                           output logic [RESULT_W-1:0] w2, output int bad);
    bad = 0;
    w1  = WORD_RESET;
    w2  = WORD_RESET;
    #3;
    for (int k = 1; k <= n; k++) begin
      if (k >= 4) begin
        w1 = {w1[RESULT_W-2:0], lane1_p_i};
        w2 = {w2[RESULT_W-2:0], lane2_p_i};
      end
      link_sck_o = 1'b1;
      #20 bad += lane_fault(diff);
      #20 link_sck_o = 1'b0;
      #20 bad += lane_fault(diff);
      #20;
    end
  endtask : sck_frame
endmodule : dasr_host_model

/* test/dasr_top_tb.sv */
// Self-checking bench for the dual converter readout and power mode controller.
`timescale 1ns/1ns
module dasr_top_tb
  import dasr_pkg::*;
;
  logic                clk_sys_i        = 1'b0;
  logic                rst_n_i          = 1'b1;
  logic                supply_ok_i      = 1'b1;
  logic                io_diff_select_i = 1'b0;
  logic [RESULT_W-1:0] ch1_code_i       = 16'hA5C3;
  logic [RESULT_W-1:0] ch2_code_i       = 16'h3C5A;
  logic                convert_strobe, sck, l1p, l1n, l2p, l2n, ecp, ecn;
  logic                sample_hold_o, conv_start_o, nap_o, sleep_o, ready_o, result_invalid_o;
  logic [RESULT_W-1:0] w1, w2;
  int                  bad;
  int                  n_mismatch  = 0;
  int                  checks_done = 0;
  int                  n_conv      = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (conv_start_o === 1'b1) n_conv <= n_conv + 1;

  dasr_top #(.POR_CYCLES(50)) i_dasr_top (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .convert_strobe_i(convert_strobe), .link_sck_i(sck),
    .io_diff_select_i(io_diff_select_i), .channel_one_serial_out_p_o(l1p),
    .channel_one_serial_out_n_o(l1n), .channel_two_serial_out_p_o(l2p),
    .channel_two_serial_out_n_o(l2n), .echoed_capture_clock_p_o(ecp),
    .echoed_capture_clock_n_o(ecn), .supply_ok_i(supply_ok_i), .ch1_code_i(ch1_code_i),
    .ch2_code_i(ch2_code_i), .sample_hold_o(sample_hold_o), .conv_start_o(conv_start_o),
    .nap_o(nap_o), .sleep_o(sleep_o), .ready_o(ready_o), .result_invalid_o(result_invalid_o));

  dasr_host_model i_dasr_host_model (
    .clk_sys_i(clk_sys_i), .lane1_p_i(l1p), .lane1_n_i(l1n), .lane2_p_i(l2p), .lane2_n_i(l2n),
    .echo_p_i(ecp), .echo_n_i(ecn), .convert_strobe_o(convert_strobe), .link_sck_o(sck));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // The settle time lets the sck events cross into the system clock domain.
  task automatic frame(input int n);
    i_dasr_host_model.sck_frame(n, io_diff_select_i, w1, w2, bad);
    repeat (12) @(negedge clk_sys_i);
  endtask : frame

  task automatic pulse(input int n);
    repeat (n) i_dasr_host_model.cnv_pulse();
  endtask : pulse

  task automatic wait_ready();
    for (int i = 0; i < 100 && ready_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk("ready", 16'h1, ready_o);
  endtask : wait_ready

  task automatic t_convert();
    int c0;
    c0 = n_conv;
    fork
      pulse(1);
      begin
        repeat (6) @(negedge clk_sys_i);
        chk("sampling", 16'h1, sample_hold_o);
        chk("early_start", 16'(c0), 16'(n_conv));
      end
    join
    chk("holding", 16'h0, sample_hold_o);
    chk("one_start", 16'(c0 + 1), 16'(n_conv));
    chk("first_invalid", 16'h1, result_invalid_o);
    frame(1);
  endtask : t_convert

  task automatic t_readout(input logic [15:0] a, input logic [15:0] b);
    ch1_code_i = a;
    ch2_code_i = b;
    pulse(1);
    frame(19);
    chk("lane1", a, w1);
    chk("lane2", b, w2);
    chk("pins", 16'h0, 16'(bad));
    ch1_code_i = ~a;
    ch2_code_i = ~b;
    pulse(1);
    chk("second_valid", 16'h0, result_invalid_o);
    frame(19);
    chk("lane1_next", ~a, w1);
    chk("lane2_next", ~b, w2);
  endtask : t_readout

  task automatic t_power();
    for (int p = 1; p <= 5; p++) begin
      pulse(1);
      chk("nap_step", 16'(p == 2 || p == 3), nap_o);
      chk("sleep_step", 16'(p == 4), sleep_o);
    end
    pulse(2);
    chk("nap_again", 16'h1, nap_o);
    frame(1);
    chk("nap_wake", 16'h0, nap_o);
    pulse(2);
    chk("count_cleared", 16'h1, nap_o);
    frame(1);
    pulse(4);
    chk("asleep", 16'h1, sleep_o);
    frame(1);
    // Sck ends sleep only in single-ended mode.
    chk("sck_wake", 16'(io_diff_select_i), 16'(sleep_o));
    // The model has no reference to recharge, so no wait follows the wake.
    if (io_diff_select_i) begin
      // Two pulses reach nap and sck ends it, so the next test starts in operation.
      pulse(2);
      frame(1);
    end
  endtask : t_power

  task automatic t_supply();
    pulse(2);
    chk("nap_before", 16'h1, nap_o);
    supply_ok_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    chk("fault_state", 16'h0, {nap_o, ready_o});
    supply_ok_i = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    chk("ready_hold", 16'h0, ready_o);
    wait_ready();
  endtask : t_supply

  initial begin
    // Link flops reset asynchronously on rst_n_i, so they reset even though sck is quiet during reset.
    #1 rst_n_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk("rst_out", 16'h0, {sample_hold_o, conv_start_o, nap_o, sleep_o, ready_o});
    chk("rst_invalid", 16'h1, result_invalid_o);
    rst_n_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    chk("ready_early", 16'h0, ready_o);
    wait_ready();
    t_convert();
    t_readout(16'hA5C3, 16'h3C5A);
    t_power();
    io_diff_select_i = 1'b1;
    frame(4);
    t_readout(16'h8001, 16'h7FFE);
    t_power();
    t_supply();
    report_and_stop();
  end

  // The tests need well under 50 us, so 400 us only trips on a hang.
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : dasr_top_tb
